// File: core/rsf_top.sv
// Purpose: rail sequencing, tracking, group and current fault configuration
// Assumes: PMBus framing decoded outside into command strobes
// Notes: inter-device bus events arrive decoded, one per cycle
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defines.svh"
module rsf_top
  import rsf_pkg::*;
#(
  parameter int RETRY_UNIT_CYC = `RSF_RETRY_UNIT_CYC,
  parameter logic [127:0] PART_ID = "RSF-PART-A1-FW01" // arbitrary value
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic wr_stb_in,
  input wire logic [7:0] wr_cmd_in,
  input wire logic [23:0] wr_data_in,
  input wire logic rd_stb_in,
  input wire logic [7:0] rd_cmd_in,
  input wire logic [3:0] rd_idx_in,
  input wire rsf_event_s event_in,
  input wire logic en_cond_in,
  input wire logic power_good_signal_in,
  input wire logic oc_fault_in,
  input wire logic uc_fault_in,
  input wire logic other_fault_in,
  input wire logic clear_faults_in,
  output logic rd_valid_out,
  output logic [23:0] rd_data_out,
  output logic rd_err_out,
  output logic wr_err_out,
  output logic out_enable_out,
  output logic fast_off_out,
  output logic [7:0] iout_status_out,
  output rsf_follow_s follow_out,
  output logic vout_load_out,
  output logic [15:0] vout_value_out
);
  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic is_writable(input logic [7:0] cmd);
    is_writable = (cmd == `RSF_CMD_RAIL_ORDER) || (cmd == `RSF_CMD_FOLLOW) ||
                  (cmd == `RSF_CMD_GROUP) || (cmd == `RSF_CMD_OC_ACT) ||
                  (cmd == `RSF_CMD_UC_ACT);
  endfunction

  function automatic logic ev_match(input rsf_event_s ev, input rsf_ev_kind_e k,
                                    input logic [4:0] id);
    ev_match = (ev.kind == k) && (ev.id == id);
  endfunction

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic [15:0] rail_order_config_r;
  logic [7:0] voltage_follow_config_r;
  logic [23:0] group_broadcast_config_r;
  logic [7:0] overcurrent_fault_action_r;
  logic [7:0] undercurrent_fault_action_r;
  logic wr_ok;

  assign wr_ok = wr_stb_in && is_writable(wr_cmd_in);

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rail_order_config_r <= `RSF_RAIL_ORDER_RST;
      voltage_follow_config_r <= `RSF_FOLLOW_RST;
      group_broadcast_config_r <= `RSF_GROUP_RST;
      overcurrent_fault_action_r <= `RSF_FAULT_ACT_RST;
      undercurrent_fault_action_r <= `RSF_FAULT_ACT_RST;
    end else if (wr_ok) begin
      unique case (wr_cmd_in)
        `RSF_CMD_RAIL_ORDER: rail_order_config_r <= wr_data_in[15:0] & `RSF_RAIL_ORDER_MASK;
        `RSF_CMD_FOLLOW: voltage_follow_config_r <= wr_data_in[7:0] & `RSF_FOLLOW_MASK;
        `RSF_CMD_GROUP: group_broadcast_config_r <= wr_data_in & `RSF_GROUP_MASK;
        `RSF_CMD_OC_ACT: overcurrent_fault_action_r <= wr_data_in[7:0];
        `RSF_CMD_UC_ACT: undercurrent_fault_action_r <= wr_data_in[7:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // command responses
  // ------------------------------------------------------------
  logic [23:0] rd_data_nxt;
  logic rd_err_nxt;

  always_comb begin
    rd_data_nxt = 24'h000000;
    rd_err_nxt = 1'b0;
    unique case (rd_cmd_in)
      `RSF_CMD_RAIL_ORDER: rd_data_nxt = {8'h00, rail_order_config_r};
      `RSF_CMD_FOLLOW: rd_data_nxt = {16'h0000, voltage_follow_config_r};
      `RSF_CMD_GROUP: rd_data_nxt = group_broadcast_config_r;
      // byte 0 is the first character of the string
      `RSF_CMD_PART_ID: rd_data_nxt = {16'h0000, PART_ID[8*(15-rd_idx_in) +: 8]};
      `RSF_CMD_OC_ACT: rd_data_nxt = {16'h0000, overcurrent_fault_action_r};
      `RSF_CMD_UC_ACT: rd_data_nxt = {16'h0000, undercurrent_fault_action_r};
      default: rd_err_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= 24'h000000;
      rd_err_out <= 1'b0;
      wr_err_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_stb_in;
      rd_data_out <= rd_stb_in ? rd_data_nxt : 24'h000000;
      rd_err_out <= rd_stb_in && rd_err_nxt;
      wr_err_out <= wr_stb_in && !is_writable(wr_cmd_in);
    end
  end

  // ------------------------------------------------------------
  // tracking controls
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      follow_out <= '0;
    end else begin
      follow_out.enable <= voltage_follow_config_r[`RSF_FOL_EN_BIT];
      follow_out.half_ratio <= voltage_follow_config_r[`RSF_FOL_HALF_BIT];
      follow_out.ref_upper <= voltage_follow_config_r[`RSF_FOL_UPPER_BIT];
      follow_out.down_allowed <= voltage_follow_config_r[`RSF_FOL_DOWN_BIT] ||
                                 power_good_signal_in;
    end
  end

  // ------------------------------------------------------------
  // inter-device bus events
  // ------------------------------------------------------------
  logic pre_en;
  logic seq_en;
  logic pre_good_ev;
  logic seq_down_ev;
  logic vout_ev;
  logic onoff_ev;
  logic pf_ev;

  assign pre_en = rail_order_config_r[`RSF_PRE_EN_BIT];
  assign seq_en = rail_order_config_r[`RSF_SEQ_EN_BIT];
  assign pre_good_ev = pre_en && ev_match(event_in, RSF_EV_POWER_GOOD,
                                          rail_order_config_r[12:8]);
  assign seq_down_ev = seq_en && ev_match(event_in, RSF_EV_POWER_DOWN,
                                          rail_order_config_r[4:0]);
  assign vout_ev = group_broadcast_config_r[`RSF_GRP_VOUT_EN_BIT] &&
                   ev_match(event_in, RSF_EV_VOUT, group_broadcast_config_r[20:16]);
  assign onoff_ev = group_broadcast_config_r[`RSF_GRP_OP_EN_BIT] &&
                    ev_match(event_in, RSF_EV_ONOFF, group_broadcast_config_r[12:8]);
  assign pf_ev = ev_match(event_in, RSF_EV_POWER_FAIL, group_broadcast_config_r[4:0]);

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vout_load_out <= 1'b0;
      vout_value_out <= 16'h0000;
    end else begin
      vout_load_out <= vout_ev;
      if (vout_ev) begin
        vout_value_out <= event_in.data;
      end
    end
  end

  // broadcast on/off state; starts on so the enable condition alone rules
  logic op_on_r;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_on_r <= 1'b1;
    end else if (onoff_ev) begin
      op_on_r <= event_in.data[0];
    end
  end

  logic run_req;
  assign run_req = en_cond_in && op_on_r;

  // preceding rail good seen; forgotten when the run request drops
  logic pre_good_r;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre_good_r <= 1'b0;
    end else if (pre_good_ev) begin
      pre_good_r <= 1'b1;
    end else if (!run_req) begin
      pre_good_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // current fault responses
  // ------------------------------------------------------------
  logic cur_fault;
  logic [7:0] act_sel;
  logic retry_forever;
  logic retry_busy;
  logic retry_go;
  logic retry_start;
  logic retry_cancel;
  rsf_state_e state_r;

  assign cur_fault = oc_fault_in || uc_fault_in;
  assign act_sel = oc_fault_in ? overcurrent_fault_action_r : undercurrent_fault_action_r;
  // anything but the forever code holds off, so unused codes never restart
  assign retry_forever = (act_sel[5:3] == `RSF_RETRY_FOREVER);
  assign retry_start = (state_r == RSF_ST_ON) && cur_fault && !other_fault_in && retry_forever;
  assign retry_cancel = (state_r == RSF_ST_FAULT) && (!run_req || other_fault_in);

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      iout_status_out <= 8'h00;
    end else begin
      // a fault in the clearing cycle wins
      if (oc_fault_in) begin
        iout_status_out[`RSF_STAT_OC_BIT] <= 1'b1;
      end else if (clear_faults_in) begin
        iout_status_out[`RSF_STAT_OC_BIT] <= 1'b0;
      end
      if (uc_fault_in) begin
        iout_status_out[`RSF_STAT_UC_BIT] <= 1'b1;
      end else if (clear_faults_in) begin
        iout_status_out[`RSF_STAT_UC_BIT] <= 1'b0;
      end
    end
  end

  rsf_retry_ctl #(
    .UNIT_CYC(RETRY_UNIT_CYC)
  ) u_retry (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .start_in(retry_start),
    .delay_code_in(act_sel[2:0]),
    .cancel_in(retry_cancel),
    .busy_out(retry_busy),
    .restart_out(retry_go)
  );

  // ------------------------------------------------------------
  // output sequencer
  // ------------------------------------------------------------
  logic hold_r;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_r <= 1'b0;
    end else if (state_r == RSF_ST_ON && cur_fault && !retry_forever) begin
      hold_r <= 1'b1;
    end else if (clear_faults_in) begin
      hold_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= RSF_ST_OFF;
      out_enable_out <= 1'b0;
      fast_off_out <= 1'b0;
    end else begin
      unique case (state_r)
        RSF_ST_OFF: begin
          if (run_req && !hold_r && !cur_fault && !other_fault_in &&
              (!pre_en || pre_good_r || pre_good_ev)) begin
            state_r <= RSF_ST_ON;
            out_enable_out <= 1'b1;
            fast_off_out <= 1'b0;
          end
        end
        RSF_ST_ON: begin
          if (cur_fault || other_fault_in) begin
            state_r <= retry_start ? RSF_ST_FAULT : RSF_ST_OFF;
            out_enable_out <= 1'b0;
            fast_off_out <= 1'b1;
          end else if (pf_ev) begin
            state_r <= RSF_ST_OFF;
            out_enable_out <= 1'b0;
            fast_off_out <= group_broadcast_config_r[`RSF_GRP_PF_FAST_BIT];
          end else if (seq_down_ev || !run_req) begin
            state_r <= RSF_ST_OFF;
            out_enable_out <= 1'b0;
            fast_off_out <= 1'b0;
          end
        end
        RSF_ST_FAULT: begin
          if (retry_cancel) begin
            state_r <= RSF_ST_OFF;
          end else if (retry_go) begin
            state_r <= RSF_ST_ON;
            out_enable_out <= 1'b1;
            fast_off_out <= 1'b0;
          end else if (!retry_busy) begin
            state_r <= RSF_ST_OFF;
          end
        end
        default: state_r <= RSF_ST_OFF;
      endcase
    end
  end
endmodule // rsf_top
`default_nettype wire

// File: core/rsf_defines.svh
// Purpose: constants of the rail sequence and fault configuration block
// Assumes: command codes and fields as seen on the PMBus side
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH
`define RSF_CMD_RAIL_ORDER 8'hE0
`define RSF_CMD_FOLLOW 8'hE1
`define RSF_CMD_GROUP 8'hE2
`define RSF_CMD_PART_ID 8'hE4
`define RSF_CMD_OC_ACT 8'hE5
`define RSF_CMD_UC_ACT 8'hE6
`define RSF_RAIL_ORDER_RST 16'h0000
`define RSF_RAIL_ORDER_MASK 16'h9F9F
`define RSF_FOLLOW_RST 8'h00
`define RSF_FOLLOW_MASK 8'h87
`define RSF_GROUP_RST 24'h000000
`define RSF_GROUP_MASK 24'h3F3F3F
`define RSF_FAULT_ACT_RST 8'h80
`define RSF_PRE_EN_BIT 15
`define RSF_SEQ_EN_BIT 7
`define RSF_FOL_EN_BIT 7
`define RSF_FOL_HALF_BIT 2
`define RSF_FOL_UPPER_BIT 1
`define RSF_FOL_DOWN_BIT 0
`define RSF_GRP_VOUT_EN_BIT 21
`define RSF_GRP_OP_EN_BIT 13
`define RSF_GRP_PF_FAST_BIT 5
`define RSF_RETRY_FOREVER 3'h7
`define RSF_STAT_OC_BIT 7
`define RSF_STAT_UC_BIT 4
`define RSF_RETRY_UNIT_MS 35
`define RSF_CLK_KHZ 40000
`define RSF_RETRY_UNIT_CYC (`RSF_RETRY_UNIT_MS * `RSF_CLK_KHZ)
`endif

// File: core/rsf_pkg.sv
// Purpose: types shared by the rail sequence and fault configuration block
// Assumes: nothing
// Notes: none
package rsf_pkg;
  typedef enum logic [2:0] {
    RSF_EV_NONE,
    RSF_EV_POWER_GOOD,
    RSF_EV_POWER_DOWN,
    RSF_EV_VOUT,
    RSF_EV_ONOFF,
    RSF_EV_POWER_FAIL
  } rsf_ev_kind_e;
  typedef struct packed {
    rsf_ev_kind_e kind;
    logic [4:0] id;
    logic [15:0] data;
  } rsf_event_s;
  typedef struct packed {
    logic enable;
    logic half_ratio;
    logic ref_upper;
    logic down_allowed;
  } rsf_follow_s;
  typedef enum logic [2:0] {
    RSF_ST_OFF,
    RSF_ST_ON,
    RSF_ST_FAULT
  } rsf_state_e;
endpackage

// File: core/rsf_retry_ctl.sv
// Purpose: restart delay timer for current fault responses
// Assumes: start and cancel are one-cycle pulses
// Notes: delay is (code+1) units
`timescale 1ns/1ps
`default_nettype none
module rsf_retry_ctl #(
  parameter int UNIT_CYC = 1400000
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic [2:0] delay_code_in,
  input wire logic cancel_in,
  output logic busy_out,
  output logic restart_out
);
  localparam int CW = $clog2(UNIT_CYC + 1);
  logic [CW-1:0] cyc_r;
  logic [2:0] units_r;
  logic busy_r;
  logic restart_r;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_r <= 1'b0;
      cyc_r <= '0;
      units_r <= 3'h0;
      restart_r <= 1'b0;
    end else begin
      restart_r <= 1'b0;
      if (cancel_in) begin
        busy_r <= 1'b0;
      end else if (start_in) begin
        busy_r <= 1'b1;
        cyc_r <= CW'(UNIT_CYC - 1);
        units_r <= delay_code_in;
      end else if (busy_r) begin
        if (cyc_r != '0) begin
          cyc_r <= cyc_r - 1'b1;
        end else if (units_r != 3'h0) begin
          units_r <= units_r - 3'h1;
          cyc_r <= CW'(UNIT_CYC - 1);
        end else begin
          busy_r <= 1'b0;
          restart_r <= 1'b1;
        end
      end
    end
  end

  assign busy_out = busy_r;
  assign restart_out = restart_r;
endmodule // rsf_retry_ctl
`default_nettype wire

// File: verif/rsf_peer_model.sv
// Purpose: peer module on the inter-device bus for the rsf_top bench
// Assumes: one request at a time, go_in is a one-cycle pulse
// Notes: id and data toggle every idle cycle so stale values never match
`timescale 1ns/1ps
`default_nettype none
module rsf_peer_model
  import rsf_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire rsf_event_s req_in,
  input wire logic [3:0] dly_in,
  output rsf_event_s ev_out
);
  rsf_event_s hold_r;
  logic [3:0] cnt_r;
  logic busy_r;
  // ----
  // event issue, dly_in+1 idle cycles after the request
  // ----
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      hold_r <= '0;
      ev_out <= '{RSF_EV_NONE, 5'h15, 16'hA5A5};
    end else begin
      ev_out <= '{RSF_EV_NONE, ~ev_out.id, ~ev_out.data};
      if (go_in) begin
        busy_r <= 1'b1;
        cnt_r <= dly_in;
        hold_r <= req_in;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        ev_out <= hold_r;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule // rsf_peer_model
`default_nettype wire

// File: verif/rsf_top_asserts.sv
// Purpose: port checker for rsf_top
// Assumes: sees only the top ports
// Notes: bound to every rsf_top below
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defines.svh"
module rsf_top_asserts
  import rsf_pkg::*;
#(
  parameter logic [127:0] PART_ID = 128'h0
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic wr_stb_in,
  input wire logic [7:0] wr_cmd_in,
  input wire logic [23:0] wr_data_in,
  input wire logic rd_stb_in,
  input wire logic [7:0] rd_cmd_in,
  input wire logic [3:0] rd_idx_in,
  input wire rsf_event_s event_in,
  input wire logic en_cond_in,
  input wire logic power_good_signal_in,
  input wire logic oc_fault_in,
  input wire logic uc_fault_in,
  input wire logic other_fault_in,
  input wire logic clear_faults_in,
  input wire logic rd_valid_out,
  input wire logic [23:0] rd_data_out,
  input wire logic rd_err_out,
  input wire logic wr_err_out,
  input wire logic out_enable_out,
  input wire logic fast_off_out,
  input wire logic [7:0] iout_status_out,
  input wire rsf_follow_s follow_out,
  input wire logic vout_load_out,
  input wire logic [15:0] vout_value_out
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  a_id_byte: assert property (
    rd_stb_in && rd_cmd_in == `RSF_CMD_PART_ID |=>
    rd_data_out == {16'h0000, PART_ID[8'h7F - {$past(rd_idx_in), 3'h0} -: 8]}) else $error("identifier byte wrong");
  a_id_ro: assert property (
    wr_stb_in && wr_cmd_in == `RSF_CMD_PART_ID |=> wr_err_out) else $error("identifier write not refused");
  a_rd_pulse: assert property (
    rd_stb_in ##1 !rd_stb_in |-> rd_valid_out ##1 !rd_valid_out) else $error("read answer not one cycle");
  a_follow_src: assert property (
    $changed({follow_out.enable, follow_out.half_ratio, follow_out.ref_upper}) |->
    $past(wr_stb_in && wr_cmd_in == `RSF_CMD_FOLLOW) || $past(wr_stb_in && wr_cmd_in == `RSF_CMD_FOLLOW, 2))
    else $error("follow mode changed without write");
  a_down_good: assert property (
    power_good_signal_in |=> follow_out.down_allowed) else $error("downward follow blocked after good");
  a_vout_src: assert property (
    vout_load_out |-> $past(event_in.kind) == RSF_EV_VOUT && vout_value_out == $past(event_in.data))
    else $error("voltage load without event");
  a_oc_off: assert property (
    out_enable_out && oc_fault_in |=> !out_enable_out && fast_off_out) else $error("overcurrent did not stop output");
  a_oc_flag: assert property (
    oc_fault_in |=> iout_status_out[`RSF_STAT_OC_BIT]) else $error("overcurrent flag not set");
  a_uc_flag: assert property (
    uc_fault_in |=> iout_status_out[`RSF_STAT_UC_BIT]) else $error("undercurrent flag not set");
  a_flag_clear: assert property (
    $fell(iout_status_out[7]) || $fell(iout_status_out[4]) |-> $past(clear_faults_in)) else $error("flag dropped");
  a_run_drop: assert property (
    !en_cond_in |=> !out_enable_out) else $error("output on without run request");
  a_other_off: assert property (
    other_fault_in |=> !out_enable_out) else $error("output on during other fault");
endmodule // rsf_top_asserts
bind rsf_top rsf_top_asserts #(.PART_ID(PART_ID)) rsf_top_asserts_i (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .wr_stb_in(wr_stb_in), .wr_cmd_in(wr_cmd_in),
  .wr_data_in(wr_data_in), .rd_stb_in(rd_stb_in), .rd_cmd_in(rd_cmd_in), .rd_idx_in(rd_idx_in),
  .event_in(event_in), .en_cond_in(en_cond_in), .power_good_signal_in(power_good_signal_in),
  .oc_fault_in(oc_fault_in), .uc_fault_in(uc_fault_in), .other_fault_in(other_fault_in),
  .clear_faults_in(clear_faults_in), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
  .rd_err_out(rd_err_out), .wr_err_out(wr_err_out), .out_enable_out(out_enable_out),
  .fast_off_out(fast_off_out), .iout_status_out(iout_status_out), .follow_out(follow_out),
  .vout_load_out(vout_load_out), .vout_value_out(vout_value_out)
);
`default_nettype wire

// File: verif/rsf_top_tb.sv
// Purpose: self-checking bench for rsf_top
// Assumes: retry unit shortened to U cycles
// Notes: register reads are checked against a queue of notes
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defines.svh"
module rsf_top_tb
  import rsf_pkg::*;
;
  localparam int U = 10;
  localparam logic [127:0] PID = "BENCH-ID-0123456";
  localparam logic [7:0] CMD [5] = '{`RSF_CMD_RAIL_ORDER, `RSF_CMD_FOLLOW, `RSF_CMD_GROUP, `RSF_CMD_OC_ACT, 8'hE6};
  localparam logic [23:0] MSK [5] = '{24'h009F9F, 24'h000087, `RSF_GROUP_MASK, 24'h0000FF, 24'h0000FF};
  localparam logic [23:0] RST [5] = '{24'h000000, 24'h000000, 24'h000000, 24'h000080, 24'h000080};
  logic mclk_in = 1'b0, rstn_in = 1'b0, wr_stb_in = 1'b0, rd_stb_in = 1'b0, en_cond_in = 1'b0;
  logic power_good_signal_in = 1'b0, oc_fault_in = 1'b0, uc_fault_in = 1'b0;
  logic other_fault_in = 1'b0, clear_faults_in = 1'b0, peer_go = 1'b0;
  logic [7:0] wr_cmd_in = 8'h00, rd_cmd_in = 8'h00;
  logic [23:0] wr_data_in = 24'h000000;
  logic [3:0] rd_idx_in = 4'h0, peer_dly = 4'h0;
  rsf_event_s event_in, peer_req = '0;
  logic rd_valid_out, rd_err_out, wr_err_out, out_enable_out, fast_off_out, vout_load_out;
  logic [23:0] rd_data_out;
  logic [7:0] iout_status_out;
  rsf_follow_s follow_out;
  logic [15:0] vout_value_out;
  logic [24:0] note_q[$];
  logic [24:0] note;
  int mismatches = 0;
  int n_tests = 0;
  rsf_top #(.RETRY_UNIT_CYC(U), .PART_ID(PID)) rsf_top_i (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .wr_stb_in(wr_stb_in), .wr_cmd_in(wr_cmd_in),
    .wr_data_in(wr_data_in), .rd_stb_in(rd_stb_in), .rd_cmd_in(rd_cmd_in), .rd_idx_in(rd_idx_in),
    .event_in(event_in), .en_cond_in(en_cond_in), .power_good_signal_in(power_good_signal_in),
    .oc_fault_in(oc_fault_in), .uc_fault_in(uc_fault_in), .other_fault_in(other_fault_in),
    .clear_faults_in(clear_faults_in), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .rd_err_out(rd_err_out), .wr_err_out(wr_err_out), .out_enable_out(out_enable_out),
    .fast_off_out(fast_off_out), .iout_status_out(iout_status_out), .follow_out(follow_out),
    .vout_load_out(vout_load_out), .vout_value_out(vout_value_out));
  rsf_peer_model rsf_peer_model_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .go_in(peer_go),
    .req_in(peer_req), .dly_in(peer_dly), .ev_out(event_in));
  // ----
  // clock, tasks and read monitor
  // ----
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] c, input logic [23:0] d, input logic [3:0] i,
                     input logic [23:0] e, input logic er);
    wr_stb_in = w;
    rd_stb_in = !w;
    wr_cmd_in = c;
    rd_cmd_in = c;
    wr_data_in = d;
    rd_idx_in = i;
    if (!w) note_q.push_back({er, e});
    tick();
  endtask
  task automatic wr(input logic [7:0] c, input logic [23:0] d);
    acc(1'b1, c, d, 4'h0, 24'h0, 1'b0);
    wr_stb_in = 1'b0;
    rd_stb_in = 1'b0;
    tick();
  endtask
  task automatic send(input rsf_ev_kind_e k, input logic [4:0] id, input logic [15:0] d, input logic [3:0] dl);
    peer_req = '{k, id, d};
    peer_dly = dl;
    peer_go = 1'b1;
    tick();
    peer_go = 1'b0;
    tick(int'(dl) + 2);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    if (rd_valid_out === 1'b1) begin
      note = note_q.size() > 0 ? note_q.pop_front() : 25'h1FFFFFF;
      chk("rd_data", note[23:0], rd_data_out);
      chk("rd_err", 24'(note[24]), 24'(rd_err_out));
    end
  end
  initial begin
    repeat (4000) @(posedge mclk_in);
    mismatches++;
    test_done();
  end
  // ----
  // scenarios
  // ----
  initial begin : main
    logic [23:0] d;
    int n;
    void'($urandom(32'h4020687f));
    tick(8);
    rstn_in = 1'b1;
    for (int i = 0; i < 5; i++) acc(1'b0, CMD[i], 24'h0, 4'h0, RST[i], 1'b0);
    for (int i = 0; i < 5; i++) begin
      d = $urandom;
      acc(1'b1, CMD[i], d, 4'h0, 24'h0, 1'b0);
      acc(1'b0, CMD[i], 24'h0, 4'h0, d & MSK[i], 1'b0);
    end
    acc(1'b0, 8'hE3, 24'h0, 4'h0, 24'h0, 1'b1);
    for (int i = 0; i < 16; i++) acc(1'b0, `RSF_CMD_PART_ID, 24'h0, i[3:0], {16'h0, PID[127 - 8 * i -: 8]}, 1'b0);
    acc(1'b1, `RSF_CMD_PART_ID, d, 4'h0, 24'h0, 1'b0);
    chk("wr_err", 24'h1, 24'(wr_err_out));
    wr(`RSF_CMD_FOLLOW, 24'h000087); // single tracking channel
    chk("follow", 24'hF, 24'(follow_out));
    wr(`RSF_CMD_FOLLOW, 24'h000080);
    chk("follow", 24'h8, 24'(follow_out));
    power_good_signal_in = 1'b1;
    tick(2);
    chk("follow", 24'h9, 24'(follow_out));
    power_good_signal_in = 1'b0;
    wr(`RSF_CMD_GROUP, 24'h252229);
    d = $urandom;
    send(RSF_EV_VOUT, 5'd5, d[15:0], 4'd0);
    chk("vload", 24'h1, 24'(vout_load_out));
    chk("vval", 24'(d[15:0]), 24'(vout_value_out));
    send(RSF_EV_VOUT, 5'd6, ~d[15:0], 4'd3);
    chk("vload", 24'h0, 24'(vout_load_out));
    wr(`RSF_CMD_RAIL_ORDER, 24'h008384);
    en_cond_in = 1'b1;
    send(RSF_EV_POWER_GOOD, 5'd2, 16'h0, 4'd1);
    chk("on", 24'h0, 24'(out_enable_out));
    send(RSF_EV_POWER_GOOD, 5'd3, 16'h0, 4'd6);
    chk("on", 24'h1, 24'(out_enable_out));
    send(RSF_EV_POWER_DOWN, 5'd5, 16'h0, 4'd0);
    chk("on", 24'h1, 24'(out_enable_out));
    send(RSF_EV_POWER_DOWN, 5'd4, 16'h0, 4'd0);
    chk("on", 24'h0, 24'(out_enable_out));
    chk("fast", 24'h0, 24'(fast_off_out));
    en_cond_in = 1'b0;
    wr(`RSF_CMD_RAIL_ORDER, 24'h000000);
    en_cond_in = 1'b1;
    tick(2);
    chk("on", 24'h1, 24'(out_enable_out));
    send(RSF_EV_ONOFF, 5'd7, 16'h0, 4'd2);
    chk("on", 24'h1, 24'(out_enable_out));
    send(RSF_EV_ONOFF, 5'd2, 16'h0, 4'd2);
    tick();
    chk("on", 24'h0, 24'(out_enable_out));
    send(RSF_EV_ONOFF, 5'd2, 16'h1, 4'd0);
    tick();
    chk("on", 24'h1, 24'(out_enable_out));
    send(RSF_EV_POWER_FAIL, 5'd9, 16'h0, 4'd1);
    chk("on", 24'h0, 24'(out_enable_out));
    chk("fast", 24'h1, 24'(fast_off_out));
    en_cond_in = 1'b0;
    wr(`RSF_CMD_GROUP, 24'h050209);
    en_cond_in = 1'b1;
    tick(2);
    send(RSF_EV_ONOFF, 5'd2, 16'h0, 4'd1);
    chk("on", 24'h1, 24'(out_enable_out));
    send(RSF_EV_VOUT, 5'd5, d[15:0], 4'd0);
    chk("vload", 24'h0, 24'(vout_load_out));
    send(RSF_EV_POWER_FAIL, 5'd9, 16'h0, 4'd1);
    chk("on", 24'h0, 24'(out_enable_out));
    chk("fast", 24'h0, 24'(fast_off_out));
    for (int i = 0; i < 4; i++) begin
      en_cond_in = 1'b0;
      wr(i[0] ? 8'hE6 : `RSF_CMD_OC_ACT, {16'h0, 2'b10, i[1] ? 3'b011 : 3'b000, 3'h1});
      en_cond_in = 1'b1;
      tick(2);
      oc_fault_in = !i[0];
      uc_fault_in = i[0];
      tick();
      oc_fault_in = 1'b0;
      uc_fault_in = 1'b0;
      chk("off", 24'h0, 24'(out_enable_out));
      chk("stat", i[0] ? 24'h10 : 24'h80, 24'(iout_status_out));
      tick(12 * U);
      chk("held", 24'h0, 24'(out_enable_out));
      clear_faults_in = 1'b1;
      tick();
      clear_faults_in = 1'b0;
      tick(2);
      chk("stat", 24'h0, 24'(iout_status_out));
      chk("on", 24'h1, 24'(out_enable_out));
    end
    d = $urandom_range(7, 0);
    wr(`RSF_CMD_OC_ACT, {16'h0, 8'hB8 | d[7:0]});
    oc_fault_in = 1'b1;
    tick();
    chk("fast", 24'h1, 24'(fast_off_out));
    n = 0;
    while (out_enable_out !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    oc_fault_in = 1'b0;
    chk("gap", 24'h1, 24'(n >= (d + 1) * U - 1 && n <= (d + 1) * U + 2));
    wr(`RSF_CMD_OC_ACT, 24'h0000B8);
    oc_fault_in = 1'b1;
    tick();
    oc_fault_in = 1'b0;
    tick(U / 2);
    en_cond_in = 1'b0;
    tick(2 * U);
    chk("cancel", 24'h0, 24'(out_enable_out));
    en_cond_in = 1'b1;
    tick(2);
    chk("on", 24'h1, 24'(out_enable_out));
    other_fault_in = 1'b1;
    oc_fault_in = 1'b1;
    tick();
    oc_fault_in = 1'b0;
    tick(3 * U);
    chk("other", 24'h0, 24'(out_enable_out));
    other_fault_in = 1'b0;
    chk("rd_left", 24'h0, 24'(note_q.size()));
    test_done();
  end
endmodule // rsf_top_tb
`default_nettype wire
